// File: hw/lcd_scan_cfg.svh
// Constants for the display memory, scan timing and register map
`ifndef LCD_SCAN_CFG_SVH
`define LCD_SCAN_CFG_SVH

// ----------------------------------------
// System clock
// ----------------------------------------
`define CLK_HZ 100000000

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_CTRL 8'h00
`define OFF_START 8'h04
`define OFF_PAGE 8'h08
`define OFF_COLUMN 8'h0c
`define OFF_DATA 8'h10
`define OFF_STATUS 8'h14

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define STATUS_BUSY_BIT 7
`define CTRL_WIDTH 11
`define CTRL_RESET 11'h060
`define BUSY_CYC 3'h4

// ----------------------------------------
// Memory geometry
// ----------------------------------------
`define NUM_PAGES 9
`define NUM_COLS 132
`define NUM_ROWS 65
`define EXTRA_PAGE 4'h8
`define LAST_COL 8'h83
`define LAST_COM 7'h3f
`define INDICATOR_COM 7'h40

// ----------------------------------------
// Oscillator and line dividers
// ----------------------------------------
`define OSC_FAST_HZ 31400
`define OSC_SLOW_HZ 26300
`define DIV_65 6'h06
`define DIV_49 6'h08
`define DIV_33 6'h0c
`define DIV_17 6'h16
`define DIV_9 6'h2c
`define LINES_65 7'h41
`define LINES_49 7'h31
`define LINES_33 7'h21
`define LINES_17 7'h11
`define LINES_9 7'h09

`endif

// File: hw/lcd_scan_pkg.sv
// Types and duty decoding shared by the scan blocks
package lcd_scan_pkg;
  `include "lcd_scan_cfg.svh"

  typedef enum logic [2:0] {DUTY_65, DUTY_49, DUTY_33, DUTY_17, DUTY_9}
    duty_t;

  typedef struct packed {
    duty_t duty;
    logic oscSlow;
    logic clockSourceSelect;
    logic masterSelect;
    logic allOn;
    logic displayOn;
    logic invert;
    logic comReverse;
    logic segDir;
  } ctrl_t;

  // The three master/slave timing pins
  typedef struct packed {
    logic displayClockPin;
    logic framePolarity;
    logic displayOffSyncN;
  } pin_bus_t;

  function automatic logic [6:0] dutyLines(input duty_t d);
    case (d)
      DUTY_49: dutyLines = `LINES_49;
      DUTY_33: dutyLines = `LINES_33;
      DUTY_17: dutyLines = `LINES_17;
      DUTY_9: dutyLines = `LINES_9;
      default: dutyLines = `LINES_65;
    endcase
  endfunction : dutyLines

  function automatic logic [5:0] dutyDivider(input duty_t d);
    case (d)
      DUTY_49: dutyDivider = `DIV_49;
      DUTY_33: dutyDivider = `DIV_33;
      DUTY_17: dutyDivider = `DIV_17;
      DUTY_9: dutyDivider = `DIV_9;
      default: dutyDivider = `DIV_65;
    endcase
  endfunction : dutyDivider
endpackage : lcd_scan_pkg

// File: hw/display_clock_gen.sv
// Oscillator model, line divider and external line clock sampling
`timescale 1ns/1ps
`include "lcd_scan_cfg.svh"
module display_clock_gen
  import lcd_scan_pkg::*;
#(
  parameter int OSC_FAST_CYC = `CLK_HZ / `OSC_FAST_HZ,
  parameter int OSC_SLOW_CYC = `CLK_HZ / `OSC_SLOW_HZ
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic oscEnable,
  input wire logic oscSlow,
  input wire duty_t duty,
  input wire logic extClockPin,
  output logic lineTick,
  output logic lineLevel
);
  typedef struct packed {
    logic [11:0] osc;
    logic [5:0] div;
    logic tick;
    logic level;
    logic [2:0] sync;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [11:0] oscLimit;
  logic [5:0] divLimit;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    oscLimit = oscSlow ? 12'(OSC_SLOW_CYC - 1) : 12'(OSC_FAST_CYC - 1);
    divLimit = dutyDivider(duty) - 6'h01;
    s_next.sync = {s_reg.sync[1:0], extClockPin};
    s_next.tick = 1'b0;
    if (oscEnable)
    begin
      s_next.osc = s_reg.osc + 12'h001;
      if (s_reg.osc >= oscLimit)
      begin
        s_next.osc = 12'h000;
        s_next.div = s_reg.div + 6'h01;
        if (s_reg.div >= divLimit)
        begin
          s_next.div = 6'h00;
          s_next.tick = 1'b1;
        end
      end
      s_next.level = (s_next.div < {1'b0, divLimit[5:1]});
    end
    else
    begin
      // Oscillator stopped, line clock taken from the pin
      s_next.osc = 12'h000;
      s_next.div = 6'h00;
      s_next.level = 1'b0;
      s_next.tick = s_reg.sync[1] & ~s_reg.sync[2];
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign lineTick = s_reg.tick;
  assign lineLevel = s_reg.level;
endmodule : display_clock_gen

// File: hw/frame_timing.sv
// Line counter, scan row arithmetic and frame polarity
`timescale 1ns/1ps
`include "lcd_scan_cfg.svh"
module frame_timing
  import lcd_scan_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic lineTick,
  input wire duty_t duty,
  input wire logic [5:0] startLine,
  input wire logic comReverse,
  output logic [6:0] scanRow,
  output logic [6:0] comIndex,
  output logic polarity
);
  typedef struct packed {
    logic [6:0] line;
    logic pol;
  } state_t;

  state_t s_reg;
  state_t s_next;
  logic [7:0] rowSum;

  // ----------------------------------------
  // Line count and polarity flip per frame
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    if (lineTick)
    begin
      if (s_reg.line >= dutyLines(duty) - 7'h01)
      begin
        s_next.line = 7'h00;
        s_next.pol = ~s_reg.pol;
      end
      else
        s_next.line = s_reg.line + 7'h01;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  // Wrap the displayed window around the 65 rows
  always_comb
  begin
    rowSum = {2'b00, startLine} + {1'b0, s_reg.line};
    if (rowSum >= 8'(`NUM_ROWS))
      scanRow = 7'(rowSum - 8'(`NUM_ROWS));
    else
      scanRow = rowSum[6:0];
    // Indicator line keeps its own output in both scan modes
    if (s_reg.line > `LAST_COM)
      comIndex = `INDICATOR_COM;
    else if (comReverse)
      comIndex = `LAST_COM - s_reg.line;
    else
      comIndex = s_reg.line;
  end

  assign polarity = s_reg.pol;
endmodule : frame_timing

// File: hw/lcd_scan_core.sv
// Display memory, APB register file, output latch and scan timing
// Overview of operation
// - While busy, every mapped access except a status read is ignored; unmapped ones still get an error.
// - Status read shows busy on data bit 7.
// - Memory is 65 rows by 132 columns, byte bits run down rows.
// - Page 8 is the single extra row, only bit 0 used.
// - Page register never advances by itself; host sets it.
// - Column increases by one after every data read or write.
// - Column stops at 83h and never carries into the page.
// - Segment direction option mirrors columns onto segment outputs.
// - Start line appears on common 0, or common 63 when reversed.
// - Each frame shows 65, 49, 33, 17 or 9 lines by duty from start line; changes apply live.
// - Invert, on/off and all-on act only on the latch path.
// - Oscillator runs only when master and clock source select high.
// - Clock source select low takes line clock from the pin.
// - Host memory access is independent of scan-out reads.
// - Row data is latched on the line clock, then drives segments.
// - Timing generator makes common timing and polarity from clock.
// - Master drives polarity, display-off, and clock only with clock source select high; slave takes them in.
// - Oscillator frequency select picks 31.4 kHz or 26.3 kHz.
// - Line clock is oscillator over 6, 8, 12, 22 or 44 by duty.
// - Polarity frequency is line clock over twice the line count.
// - First read after address set or write returns stale data.
`timescale 1ns/1ps
`include "lcd_scan_cfg.svh"
module lcd_scan_core
  import lcd_scan_pkg::*;
#(
  parameter int NUM_COLS = `NUM_COLS,
  parameter int NUM_PAGES = `NUM_PAGES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pin_bus_t pinIn,
  output pin_bus_t pinOut,
  output pin_bus_t pinOe,
  output logic [NUM_COLS-1:0] segOut,
  output logic [6:0] comIndex,
  output logic framePolarity
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    ctrl_t ctrl;
    logic [5:0] start;
    logic [3:0] page;
    logic [7:0] col;
    logic [7:0] hold;
    logic [2:0] busy;
    logic ready;
    logic err;
    logic [31:0] rdata;
    logic [NUM_COLS-1:0] latch;
    logic [NUM_COLS-1:0] seg;
    logic [6:0] com;
    logic [1:0] frameSync;
    logic [1:0] offSync;
    logic [NUM_PAGES-1:0][NUM_COLS-1:0][7:0] mem;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic lineTick;
  logic lineLevel;
  logic oscEnable;
  logic timingPol;
  logic [6:0] scanRow;
  logic [6:0] timingCom;
  logic [3:0] rowPage;
  logic [2:0] rowBit;
  logic [NUM_COLS-1:0] rowData;

  // Bus decode and display helpers
  logic access;
  logic blocked;
  logic mapped;
  logic pageOk;
  logic colOk;
  logic [7:0] nextCol;
  logic [7:0] cellRead;
  logic offLevel;
  logic blank;
  logic pix;

  // ----------------------------------------
  // Clock source and frame timing
  // ----------------------------------------
  // Only a master with the internal source lets the oscillator run
  assign oscEnable = s_reg.ctrl.masterSelect &
    s_reg.ctrl.clockSourceSelect;

  display_clock_gen clock_gen
  (
    .clock(clock),
    .rst(rst),
    .oscEnable(oscEnable),
    .oscSlow(s_reg.ctrl.oscSlow),
    .duty(s_reg.ctrl.duty),
    .extClockPin(pinIn.displayClockPin),
    .lineTick(lineTick),
    .lineLevel(lineLevel)
  );

  frame_timing timing
  (
    .clock(clock),
    .rst(rst),
    .lineTick(lineTick),
    .duty(s_reg.ctrl.duty),
    .startLine(s_reg.start),
    .comReverse(s_reg.ctrl.comReverse),
    .scanRow(scanRow),
    .comIndex(timingCom),
    .polarity(timingPol)
  );

  // ----------------------------------------
  // Scan-side row read
  // ----------------------------------------
  // Separate read port from the host path, so host traffic never
  // disturbs the picture
  assign rowPage = scanRow[6:3];
  assign rowBit = scanRow[2:0];

  generate
    for (genvar c = 0; c < NUM_COLS; c++)
    begin : gen_row
      assign rowData[c] = s_reg.mem[rowPage][c][rowBit];
    end
  endgenerate

  // ----------------------------------------
  // Host address helpers
  // ----------------------------------------
  always_comb
  begin
    pageOk = (s_reg.page <= `EXTRA_PAGE);
    colOk = (s_reg.col <= `LAST_COL);
    // Saturate at the last column, page left alone
    if (s_reg.col < `LAST_COL)
      nextCol = s_reg.col + 8'h01;
    else
      nextCol = s_reg.col;
    cellRead = 8'h00;
    if (pageOk && colOk)
      cellRead = s_reg.mem[s_reg.page][s_reg.col];
    if (s_reg.page == `EXTRA_PAGE)
      cellRead = {7'h00, cellRead[0]};
  end

  // ----------------------------------------
  // Next state: bus, memory, latch
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.ready = 1'b0;
    s_next.err = 1'b0;
    s_next.frameSync = {s_reg.frameSync[0], pinIn.framePolarity};
    s_next.offSync = {s_reg.offSync[0], pinIn.displayOffSyncN};
    if (s_reg.busy != 3'h0)
      s_next.busy = s_reg.busy - 3'h1;

    // One wait state: act in the first access cycle, answer next
    access = psel & penable & ~s_reg.ready;
    blocked = (s_reg.busy != 3'h0) &&
      !(!pwrite && paddr == `OFF_STATUS);
    mapped = 1'b1;

    if (access)
    begin
      s_next.ready = 1'b1;
      s_next.rdata = 32'h0000_0000;
      case (paddr)
        `OFF_CTRL:
        begin
          if (pwrite && !blocked)
            s_next.ctrl = ctrl_t'(pwdata[`CTRL_WIDTH-1:0]);
          else if (!blocked)
            s_next.rdata = {21'h000000, s_reg.ctrl};
        end
        `OFF_START:
        begin
          // Takes effect at the next scanned line
          if (pwrite && !blocked)
            s_next.start = pwdata[5:0];
          else if (!blocked)
            s_next.rdata = {26'h0000000, s_reg.start};
        end
        `OFF_PAGE:
        begin
          if (pwrite && !blocked)
            s_next.page = pwdata[3:0];
          else if (!blocked)
            s_next.rdata = {28'h0000000, s_reg.page};
        end
        `OFF_COLUMN:
        begin
          if (pwrite && !blocked)
            s_next.col = pwdata[7:0];
          else if (!blocked)
            s_next.rdata = {24'h000000, s_reg.col};
        end
        `OFF_DATA:
        begin
          if (pwrite && !blocked)
          begin
            // Out of range cells are dropped, column still moves unless at or past 83h
            if (pageOk && colOk)
            begin
              if (s_reg.page == `EXTRA_PAGE)
                s_next.mem[s_reg.page][s_reg.col] =
                  {7'h00, pwdata[0]};
              else
                s_next.mem[s_reg.page][s_reg.col] = pwdata[7:0];
            end
            s_next.col = nextCol;
          end
          else if (!blocked)
          begin
            // Holding buffer answers, then refills from the cell
            s_next.rdata = {24'h000000, s_reg.hold};
            s_next.hold = cellRead;
            s_next.col = nextCol;
          end
        end
        `OFF_STATUS:
        begin
          if (!pwrite)
            s_next.rdata[`STATUS_BUSY_BIT] = (s_reg.busy != 3'h0);
        end
        default:
        begin
          mapped = 1'b0;
          s_next.err = 1'b1;
        end
      endcase
      // Any accepted write other than to status keeps the block busy for a short while
      if (pwrite && !blocked && mapped && paddr != `OFF_STATUS)
        s_next.busy = `BUSY_CYC;
    end

    // Capture the scanned row on each line clock
    if (lineTick)
    begin
      s_next.latch = rowData;
      s_next.com = timingCom;
    end

    // Display controls work on the latch copy only
    offLevel = s_reg.ctrl.masterSelect ? s_reg.ctrl.displayOn :
      s_reg.offSync[1];
    blank = ~offLevel;
    pix = 1'b0;
    for (int i = 0; i < NUM_COLS; i++)
    begin
      if (s_reg.ctrl.segDir)
        pix = s_reg.latch[NUM_COLS-1-i];
      else
        pix = s_reg.latch[i];
      s_next.seg[i] = ~blank &
        (s_reg.ctrl.allOn | (pix ^ s_reg.ctrl.invert));
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= '0;
      s_reg.ctrl <= `CTRL_RESET;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = s_reg.rdata;
  assign pready = s_reg.ready;
  assign pslverr = s_reg.err;
  assign segOut = s_reg.seg;
  assign comIndex = s_reg.com;

  // Master drives polarity and display-off, plus clock when the oscillator runs; a slave follows
  assign pinOut.displayClockPin = lineLevel;
  assign pinOut.framePolarity = timingPol;
  assign pinOut.displayOffSyncN = s_reg.ctrl.displayOn;
  assign pinOe.displayClockPin = oscEnable;
  assign pinOe.framePolarity = s_reg.ctrl.masterSelect;
  assign pinOe.displayOffSyncN = s_reg.ctrl.masterSelect;

  // Slave takes polarity from the master, synchronised first
  assign framePolarity = s_reg.ctrl.masterSelect ? timingPol :
    s_reg.frameSync[1];
endmodule : lcd_scan_core

// File: verification/lcd_scan_core_properties.sv
// Port-level checks on the scan core, bound into its top
`timescale 1ns/1ps
module lcd_scan_core_properties
  import lcd_scan_pkg::*;
#(
  parameter int NUM_COLS = 132
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire pin_bus_t pinIn,
  input wire pin_bus_t pinOut,
  input wire pin_bus_t pinOe,
  input wire logic [NUM_COLS-1:0] segOut,
  input wire logic [6:0] comIndex,
  input wire logic framePolarity
);
  logic take;
  logic mapped;
  logic [3:0] sinceWr;
  assign take = psel && penable && !pready;
  assign mapped = paddr <= 8'h10 && paddr[1:0] == 2'h0;
  // Edges since a write that surely opened the busy window
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      sinceWr <= 4'hf;
    else if (take && pwrite && mapped && sinceWr >= 4'h8)
      sinceWr <= 4'h0;
    else if (sinceWr != 4'hf)
      sinceWr <= sinceWr + 4'h1;
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence s_bad_take;
    take && (paddr > 8'h14 || paddr[1:0] != 2'h0);
  endsequence
  sequence s_err_answer;
    pready && pslverr && prdata == 32'h0;
  endsequence
  a_one_wait: assert property (take |=> pready)
    else $error("access not answered after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_unmapped_error: assert property (s_bad_take |=> s_err_answer)
    else $error("unmapped access not flagged");
  a_status_busy: assert property (
    pready && !pwrite && paddr == 8'h14 && sinceWr <= 4'h4
    |-> prdata == 32'h80) else $error("busy not shown on bit 7");
  a_status_bits: assert property (
    pready && !pwrite && paddr == 8'h14
    |-> prdata[31:8] == 24'h0 && prdata[6:0] == 7'h0)
    else $error("status holds bits other than busy");
  a_busy_refuse: assert property (
    pready && !pwrite && mapped && sinceWr <= 4'h4
    |-> prdata == 32'h0 && !pslverr) else $error("busy read answered");
  a_com_range: assert property (comIndex <= 7'h40)
    else $error("common index out of range");
  a_clock_master: assert property (
    pinOe.displayClockPin |-> pinOe.framePolarity && pinOe.displayOffSyncN)
    else $error("clock driven while not master");
  a_blank_off: assert property (
    (pinOe.displayOffSyncN && !pinOut.displayOffSyncN)[*3] |-> segOut == '0)
    else $error("segments lit while display off");
  a_polarity_hold: assert property (
    $changed(framePolarity) && pinOe.framePolarity
    |=> ($stable(framePolarity) || !pinOe.framePolarity)[*8])
    else $error("polarity toggled inside a frame");
endmodule : lcd_scan_core_properties

bind lcd_scan_core lcd_scan_core_properties #(.NUM_COLS(NUM_COLS)) props (
  .clock(clock), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pinIn(pinIn), .pinOut(pinOut),
  .pinOe(pinOe), .segOut(segOut), .comIndex(comIndex),
  .framePolarity(framePolarity));

// File: verification/lcd_far_side.sv
// Far-side master that supplies line clock, polarity and display-on pins
`timescale 1ns/1ps
module lcd_far_side
  import lcd_scan_pkg::*;
(
  input wire logic clock,
  input wire logic run,
  input wire logic [6:0] lines,
  output pin_bus_t pins,
  output int edges
);
  int div = 0;
  int lineCnt = 0;
  initial pins = 3'h1;
  initial edges = 0;
  // Line clock stands still while run is low; polarity flips per frame
  always @(posedge clock)
  begin
    if (!run)
    begin
      div <= 0;
      pins.displayClockPin <= 1'h0;
    end
    else if (div == 7)
    begin
      div <= 0;
      pins.displayClockPin <= !pins.displayClockPin;
      if (!pins.displayClockPin)
      begin
        edges <= edges + 1;
        lineCnt <= (lineCnt == int'(lines) - 1) ? 0 : lineCnt + 1;
        if (lineCnt == int'(lines) - 1)
          pins.framePolarity <= !pins.framePolarity;
      end
    end
    else
      div <= div + 1;
  end
endmodule : lcd_far_side

// File: verification/lcd_scan_core_bench.sv
// Self-checking bench for the scan core
`timescale 1ns/1ps
module lcd_scan_core_bench
  import lcd_scan_pkg::*;
;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [31:0] data;
    logic chk;
  } row_t;
  logic clock = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0;
  logic pwrite = 1'h0, pready, pslverr, framePolarity, run = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [131:0] segOut;
  logic [6:0] comIndex;
  pin_bus_t pinIn, pinOut, pinOe, farPins;
  int edges, miscompares = 0, checksDone = 0;
  row_t rows[27] = '{'{1'h0,8'h00,32'h60,1'h1}, '{1'h0,8'h14,32'h0,1'h1},
    '{1'h1,8'h04,32'h3f,1'h0}, '{1'h0,8'h04,32'h3f,1'h1},
    '{1'h1,8'h08,32'h3,1'h0}, '{1'h1,8'h0c,32'h82,1'h0},
    '{1'h1,8'h10,32'ha5,1'h0}, '{1'h1,8'h10,32'h5a,1'h0},
    '{1'h1,8'h10,32'hff,1'h0}, '{1'h0,8'h0c,32'h83,1'h1},
    '{1'h0,8'h08,32'h3,1'h1}, '{1'h1,8'h0c,32'h82,1'h0},
    '{1'h0,8'h10,32'h0,1'h0}, '{1'h0,8'h10,32'ha5,1'h1},
    '{1'h0,8'h10,32'hff,1'h1}, '{1'h1,8'h08,32'h8,1'h0},
    '{1'h1,8'h0c,32'h0,1'h0}, '{1'h1,8'h10,32'hfe,1'h0},
    '{1'h1,8'h10,32'h03,1'h0}, '{1'h1,8'h0c,32'h0,1'h0},
    '{1'h0,8'h10,32'h0,1'h0}, '{1'h0,8'h10,32'h0,1'h1},
    '{1'h0,8'h10,32'h1,1'h1}, '{1'h0,8'h08,32'h8,1'h1},
    '{1'h1,8'h08,32'h0,1'h0}, '{1'h1,8'h0c,32'h0,1'h0},
    '{1'h1,8'h10,32'h01,1'h0}};
  // Control word, start line, common, column, expected segment
  int sc[9][5] = '{'{'h428,0,0,0,1}, '{'h429,0,0,131,1}, '{'h42c,0,1,0,1},
    '{'h42c,0,0,0,0}, '{'h42a,0,63,0,1}, '{'h428,63,2,0,1},
    '{'h428,63,1,1,1}, '{'h438,0,0,1,1}, '{'h420,0,0,0,0}};
  always #5 clock = !clock;
  // Shared pins resolve to whichever party enables them
  assign pinIn.displayClockPin = pinOe.displayClockPin ?
    pinOut.displayClockPin : farPins.displayClockPin;
  assign pinIn.framePolarity = pinOe.framePolarity ?
    pinOut.framePolarity : farPins.framePolarity;
  assign pinIn.displayOffSyncN = pinOe.displayOffSyncN ?
    pinOut.displayOffSyncN : farPins.displayOffSyncN;
  lcd_scan_core dut (.clock(clock), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .segOut(segOut), .comIndex(comIndex),
    .framePolarity(framePolarity));
  lcd_far_side far (.clock(clock), .run(run), .lines(7'h09),
    .pins(farPins), .edges(edges));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic giveVerdict;
    if (miscompares == 0 && checksDone > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : giveVerdict
  // Request is held until ready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic e);
    int n;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    check({31'h0, pready}, 32'h1);
    r = prdata;
    e = pslverr;
    penable <= 1'h0;
  endtask : apb
  // Idle gap long enough to clear the busy window
  task automatic idle(input int k);
    psel <= 1'h0;
    repeat (k) @(posedge clock);
  endtask : idle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
    idle(9);
  endtask : wr
  task automatic b2b(input logic [7:0] a1, input logic [31:0] d1,
    input logic w2, input logic [7:0] a2, output logic [31:0] r);
    logic e;
    apb(1'h1, a1, d1, r, e);
    apb(w2, a2, 32'h2, r, e);
    idle(9);
  endtask : b2b
  // Waits for a fresh latch of the given common line
  task automatic scan(input int s[5], output logic [31:0] seg);
    int n;
    wr(8'h00, s[0]);
    wr(8'h04, s[1]);
    n = 0;
    while (comIndex === s[2][6:0] && n < 400)
    begin
      @(posedge clock);
      n++;
    end
    while (comIndex !== s[2][6:0] && n < 800)
    begin
      @(posedge clock);
      n++;
    end
    repeat (2) @(posedge clock);
    seg = {31'h0, segOut[s[3]]};
  endtask : scan
  task automatic flip(output int e);
    logic p;
    int n;
    p = framePolarity;
    n = 0;
    while (framePolarity === p && n < 2000)
    begin
      @(posedge clock);
      n++;
    end
    e = edges;
  endtask : flip
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] r;
    logic e;
    int e0, e1;
    repeat (10) @(posedge clock);
    check({29'h0, pinOe}, 32'h7);
    rst <= 1'h0;
    @(posedge clock);
    for (int i = 0; i < 27; i++)
    begin
      apb(rows[i].wr, rows[i].addr, rows[i].data, r, e);
      idle(9);
      if (rows[i].chk)
        check(r, rows[i].data);
    end
    b2b(8'h08, 32'h5, 1'h0, 8'h14, r);
    check(r, 32'h80);
    b2b(8'h08, 32'h6, 1'h0, 8'h08, r);
    check(r, 32'h0);
    b2b(8'h0c, 32'h7, 1'h1, 8'h08, r);
    apb(1'h0, 8'h08, 32'h0, r, e);
    idle(2);
    check(r, 32'h6);
    apb(1'h0, 8'h18, 32'h0, r, e);
    idle(2);
    check({31'h0, e}, 32'h1);
    run <= 1'h1;
    for (int i = 0; i < 9; i++)
    begin
      scan(sc[i], r);
      check(r, sc[i][4]);
      check({25'h0, comIndex}, sc[i][2]);
    end
    check({29'h0, pinOe}, 32'h3);
    flip(e0);
    flip(e1);
    check(e1 - e0, 32'h9);
    wr(8'h00, 32'h408);
    check({29'h0, pinOe}, 32'h0);
    // Slave polarity follows the far-side master once per frame
    flip(e0);
    flip(e1);
    check(e1 - e0, 32'h9);
    rst <= 1'h1;
    repeat (2) @(posedge clock);
    check({29'h0, pinOe}, 32'h7);
    rst <= 1'h0;
    @(posedge clock);
    apb(1'h0, 8'h00, 32'h0, r, e);
    idle(2);
    check(r, 32'h60);
    giveVerdict();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    #300000;
    miscompares++;
    giveVerdict();
  end
endmodule : lcd_scan_core_bench
